//--- shared/fcs_pkg.sv
// Constants, register map and types of the configuration sequencer
package fcs_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS   = 50;
  localparam int CRESET_MIN_NS   = 320;
  localparam int DATA_DELAY_NS   = 1200;
  localparam int USER_MIN_NS     = 12000;
  // Least times round up to whole cycles
  localparam int CRESET_MIN_CYC  =
    (CRESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DATA_DELAY_CYC  =
    (DATA_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int USER_MIN_CYC    =
    (USER_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CHAIN_BITS      = 1344;
  // Half periods of the active-mode clock, in hclk cycles
  localparam logic [2:0] HALF_BY_FOUR  = 3'h2;
  localparam logic [2:0] HALF_BY_EIGHT = 3'h4;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] LENGTH_OFS = 8'h08;
  localparam logic [7:0] COUNT_OFS  = 8'h0c;
  localparam int CTRL_BITS          = 6;
  localparam logic [5:0]  CTRL_RESET   = 6'h00;
  localparam logic [31:0] LENGTH_RESET = 32'h0000_0100;
  // Status field positions
  localparam int ST_SUM_LSB  = 0;
  localparam int ST_BY_EIGHT_BIT = 16;
  localparam int ST_BUSY_BIT = 17;
  localparam int ST_DONE_BIT = 18;
  localparam int ST_USER_BIT = 19;
  localparam int ST_CHN_BIT  = 20;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    FCS_X1, FCS_X2, FCS_X4, FCS_X8
  } fcs_width_t;

  typedef struct packed {
    logic       chain_master;
    logic       jtag_mode;
    logic       passive;
    logic       clock_divide_by_eight;
    fcs_width_t width;
  } fcs_ctrl_t;

  typedef enum {
    ST_IDLE, ST_DELAY, ST_LOAD, ST_DONE, ST_USER
  } fcs_state_t;

endpackage

//--- core/fcs_sync3.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ns
module fcs_sync3 #(
  parameter int W = 1
) (
  input  wire logic         hclk,     // System clock
  input  wire logic         hresetn,  // Async reset, active low
  input  wire logic [W-1:0] d,        // Asynchronous pin level
  output logic      [W-1:0] q         // Filtered level
);
  logic [W-1:0] ff1;
  logic [W-1:0] ff2;
  logic [W-1:0] ff3;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ff1 <= '0;
      ff2 <= '0;
      ff3 <= '0;
    end else begin
      ff1 <= d;
      ff2 <= ff1;
      ff3 <= ff2;
    end
  end

  // Change taken once stages two and three agree
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= '0;
    end else begin
      for (int i = 0; i < W; i++) begin
        if (ff2[i] == ff3[i]) begin
          q[i] <= ff3[i];
        end
      end
    end
  end
endmodule // fcs_sync3

//--- core/fcs_clk_div.sv
// Active-mode configuration clock divider
`timescale 1ns/1ns
module fcs_clk_div
  import fcs_pkg::*;
(
  input  wire logic hclk,     // System clock
  input  wire logic hresetn,  // Async reset, active low
  input  wire logic run,      // Clock runs while high
  input  wire logic by_eight, // Divide by eight, else by four
  output logic      cclk,     // Divided clock level
  output logic      rise      // Pulse on each rising edge
);
  logic [2:0] cnt;
  logic [2:0] half;

  assign half = by_eight ? HALF_BY_EIGHT : HALF_BY_FOUR;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt  <= 3'h0;
      cclk <= 1'b0;
      rise <= 1'b0;
    end else if (!run) begin
      cnt  <= 3'h0;
      cclk <= 1'b0;
      rise <= 1'b0;
    end else if (cnt == half - 3'h1) begin
      cnt  <= 3'h0;
      cclk <= ~cclk;
      rise <= ~cclk;
    end else begin
      cnt  <= cnt + 3'h1;
      rise <= 1'b0;
    end
  end
endmodule // fcs_clk_div

//--- core/fcs_sequencer.sv
// Configuration timing sequencer with AHB-Lite register access
// Function
// [RULE1] Reconfiguration starts only after reset pin low at least 320 ns.
// [RULE2] After done rises, wait at least 12 us before user mode.
// [RULE3] System should hold its device interface in reset until delay ends.
// [RULE4] In JTAG mode, delay counts after done and enter-user in UPDATE_IR.
// [RULE5] Active mode clock from divider, divide by four or by eight.
// [RULE6] Parallel chain at x2 or x4 forces the divide-by-four setting.
// [RULE7] Passive x1 external clock is at most 25 MHz.
// [RULE8] Passive x2, x4, x8 external clock is at most 50 MHz.
// [RULE9] Passive clock high and low each at least 0.48 of period.
// [RULE10] Host waits 1.2 us after reset release before first data.
// [RULE11] TDO changes on the TCK falling edge.
// [RULE12] Chain master delay adds 1344 over width config clock periods.
// [RULE13] Done flag low during loading, high once all data accepted.
`timescale 1ns/1ns
module fcs_sequencer (
  input  wire logic        hclk,             // System clock, 20 MHz
  input  wire logic        hresetn,          // Async reset, active low
  input  wire logic        hsel,             // Slave select
  input  wire logic [31:0] haddr,            // Address
  input  wire logic [1:0]  htrans,           // Transfer type
  input  wire logic        hwrite,           // Write when high
  input  wire logic [2:0]  hsize,            // Transfer size
  input  wire logic [31:0] hwdata,           // Write data
  input  wire logic        hready,           // Bus ready
  output logic      [31:0] hrdata,           // Read data
  output logic             hreadyout,        // Slave ready
  output logic             hresp,            // Response, always OKAY
  input  wire logic        creset_n,         // Config reset pin
  input  wire logic        config_clock_i,   // Config clock pin in
  output logic             config_clock_o,   // Config clock pin out
  output logic             config_clock_oe,  // Config clock drive
  input  wire logic [7:0]  config_data,      // Config data pins
  output logic             config_done_flag, // Configuration done
  output logic             user_mode,        // Device in user mode
  input  wire logic        tck,              // JTAG clock pin
  input  wire logic        tdi,              // JTAG data in pin
  output logic             tdo,              // JTAG data out pin
  input  wire logic        tap_update_ir,    // TAP in UPDATE_IR
  input  wire logic        tap_capture_dr,   // TAP capture pulse
  input  wire logic        enter_user_cmd    // Enter-user decoded
);
  import fcs_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic       creset_act;
  logic [8:0] pdat_s;
  logic [1:0] jtag_s;

  // Pin inverted so the synchroniser reset value is the idle level
  fcs_sync3 #(.W(1)) u_sync_rst (
    .hclk    (hclk),
    .hresetn (hresetn),
    .d       (!creset_n),
    .q       (creset_act)
  );

  // Clock and data synchronised together to keep them aligned
  fcs_sync3 #(.W(9)) u_sync_dat (
    .hclk    (hclk),
    .hresetn (hresetn),
    .d       ({config_clock_i, config_data}),
    .q       (pdat_s)
  );

  fcs_sync3 #(.W(2)) u_sync_jtg (
    .hclk    (hclk),
    .hresetn (hresetn),
    .d       ({tck, tdi}),
    .q       (jtag_s)
  );

  // ----------------------------------------------------------------
  // Registers and state
  // ----------------------------------------------------------------
  fcs_ctrl_t   ctrl;
  logic [31:0] length;
  logic [31:0] accepted;
  logic [15:0] checksum;
  fcs_state_t  state;
  logic        start;
  logic        by_eight_eff;
  logic        div_run;
  logic        div_cclk;
  logic        div_rise;
  logic        tick;
  logic        pclk_prev;
  logic        creset_prev;
  logic [3:0]  low_cnt;
  logic [7:0]  delay_cnt;
  logic [7:0]  user_cnt;
  logic [10:0] chain_cnt;
  logic [10:0] chain_need;
  logic        jtag_armed;
  logic        user_timer_done;
  logic        chain_pending;
  logic [7:0]  data_mask;

  // ----------------------------------------------------------------
  // Reset pulse qualification
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      creset_prev <= 1'b0;
      low_cnt     <= 4'h0;
      start       <= 1'b0;
    end else begin
      creset_prev <= creset_act;
      start       <= 1'b0;
      if (creset_act) begin
        if (low_cnt != CRESET_MIN_CYC[3:0]) begin
          low_cnt <= low_cnt + 4'h1;
        end
      end else begin
        low_cnt <= 4'h0;
        if (creset_prev && low_cnt == CRESET_MIN_CYC[3:0]) begin
          start <= 1'b1; // RULE1
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Config clock selection
  // ----------------------------------------------------------------
  // Chained x2 or x4 must run at the faster setting
  assign by_eight_eff = ctrl.clock_divide_by_eight &
                        !(ctrl.chain_master &&
                          (ctrl.width == FCS_X2 ||
                           ctrl.width == FCS_X4)); // RULE6
  assign chain_pending = ctrl.chain_master && chain_cnt != chain_need;
  assign div_run = !ctrl.passive &&
                   (state == ST_LOAD || (state == ST_DONE && chain_pending));
  assign tick = ctrl.passive ? (pdat_s[8] && !pclk_prev) : div_rise;
  assign chain_need = 11'(CHAIN_BITS >> ctrl.width); // RULE12
  assign user_timer_done = user_cnt == USER_MIN_CYC[7:0];

  always_comb begin
    unique case (ctrl.width)
      FCS_X1: data_mask = 8'h01;
      FCS_X2: data_mask = 8'h03;
      FCS_X4: data_mask = 8'h0f;
      FCS_X8: data_mask = 8'hff;
    endcase
  end

  fcs_clk_div u_div (
    .hclk    (hclk),
    .hresetn (hresetn),
    .run     (div_run),
    .by_eight (by_eight_eff),
    .cclk    (div_cclk),
    .rise    (div_rise)
  ); // RULE5

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pclk_prev       <= 1'b0;
      config_clock_o  <= 1'b0;
      config_clock_oe <= 1'b0;
    end else begin
      pclk_prev       <= pdat_s[8];
      config_clock_o  <= div_cclk;
      config_clock_oe <= !ctrl.passive;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state      <= ST_IDLE;
      delay_cnt  <= 8'h0;
      user_cnt   <= 8'h0;
      chain_cnt  <= 11'h0;
      jtag_armed <= 1'b0;
      accepted   <= 32'h0;
      checksum   <= 16'h0;
    end else if (start) begin
      state      <= ST_DELAY;
      delay_cnt  <= 8'h0;
      user_cnt   <= 8'h0;
      chain_cnt  <= 11'h0;
      jtag_armed <= 1'b0;
      accepted   <= 32'h0;
      checksum   <= 16'h0;
    end else begin
      unique case (state)
        ST_IDLE: ;
        ST_DELAY: begin
          // Clocks before the data delay ends are ignored
          if (delay_cnt == DATA_DELAY_CYC[7:0] - 8'h1) begin
            state <= ST_LOAD; // RULE10
          end else begin
            delay_cnt <= delay_cnt + 8'h1;
          end
        end
        ST_LOAD: begin
          if (tick) begin
            accepted <= accepted + 32'h1;
            checksum <= {checksum[14:0], checksum[15]} ^
                        {8'h00, pdat_s[7:0] & data_mask};
            if (accepted + 32'h1 >= length) begin
              state <= ST_DONE; // RULE13
            end
          end
        end
        ST_DONE: begin
          if (ctrl.jtag_mode && enter_user_cmd && tap_update_ir) begin
            jtag_armed <= 1'b1; // RULE4
          end
          if ((!ctrl.jtag_mode || jtag_armed) && !user_timer_done) begin
            user_cnt <= user_cnt + 8'h1; // RULE2 RULE4
          end
          if (chain_pending && tick) begin
            chain_cnt <= chain_cnt + 11'h1; // RULE12
          end
          if (user_timer_done && !chain_pending) begin
            state <= ST_USER; // RULE2 RULE12
          end
        end
        ST_USER: ;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      config_done_flag <= 1'b0;
      user_mode        <= 1'b0;
    end else begin
      config_done_flag <= state == ST_DONE || state == ST_USER; // RULE13
      user_mode        <= state == ST_USER; // RULE2
    end
  end

  // ----------------------------------------------------------------
  // JTAG data shift, TDO moves on falling TCK
  // ----------------------------------------------------------------
  logic       tck_prev;
  logic [7:0] jshift;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tck_prev <= 1'b0;
      jshift   <= 8'h00;
      tdo      <= 1'b0;
    end else begin
      tck_prev <= jtag_s[1];
      if (tap_capture_dr) begin
        jshift <= {4'h0, user_mode, config_done_flag,
                   state != ST_IDLE, jtag_armed};
      end else if (jtag_s[1] && !tck_prev) begin
        jshift <= {jtag_s[0], jshift[7:1]};
      end
      if (!jtag_s[1] && tck_prev) begin
        tdo <= jshift[0]; // RULE11
      end
    end
  end

  // ----------------------------------------------------------------
  // AHB-Lite slave
  // ----------------------------------------------------------------
  logic        wr_pend;
  logic [7:0]  wr_addr;
  logic [31:0] rd_value;

  always_comb begin
    rd_value = 32'h0;
    unique case (haddr[7:0])
      CTRL_OFS:   rd_value = {26'h0, ctrl};
      STATUS_OFS: begin
        rd_value[ST_SUM_LSB +: 16] = checksum;
        rd_value[ST_BY_EIGHT_BIT]  = by_eight_eff;
        rd_value[ST_BUSY_BIT]      = state == ST_DELAY ||
                                     state == ST_LOAD;
        rd_value[ST_DONE_BIT]      = config_done_flag;
        rd_value[ST_USER_BIT]      = user_mode;
        rd_value[ST_CHN_BIT]       = chain_pending;
      end
      LENGTH_OFS: rd_value = length;
      COUNT_OFS:  rd_value = accepted;
      default:    rd_value = 32'h0;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend   <= 1'b0;
      wr_addr   <= 8'h00;
      hrdata    <= 32'h0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      wr_pend <= 1'b0;
      if (hsel && hready && htrans[1]) begin
        wr_pend <= hwrite;
        wr_addr <= haddr[7:0];
        if (!hwrite) begin
          hrdata <= rd_value;
        end
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl   <= fcs_ctrl_t'(CTRL_RESET);
      length <= LENGTH_RESET;
    end else if (wr_pend) begin
      unique case (wr_addr)
        CTRL_OFS:   ctrl   <= fcs_ctrl_t'(hwdata[CTRL_BITS-1:0]);
        LENGTH_OFS: length <= hwdata;
        default:    ;
      endcase
    end
  end
endmodule // fcs_sequencer

//--- testbench/fcs_seq_properties.sv
// Checker: timing properties of the configuration sequencer
`timescale 1ns/1ns
module fcs_seq_props
  import fcs_pkg::*;
(
  input wire logic hclk,             // Clock
  input wire logic hresetn,          // Reset, low
  input wire logic hreadyout,        // Slave ready
  input wire logic hresp,            // Response
  input wire logic creset_n,         // Config reset
  input wire logic config_clock_o,   // Config clock
  input wire logic config_done_flag, // Done flag
  input wire logic user_mode,        // User mode
  input wire logic tck,              // JTAG clock
  input wire logic tdo               // JTAG out
);
  logic [9:0] done_n;
  logic [9:0] low_n;
  logic [9:0] last_low;
  logic [3:0] tck_n;

  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // --------------------------------------------------------------
  // Helper counters
  // --------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) done_n <= 10'h000;
    else if (!config_done_flag) done_n <= 10'h000;
    else if (done_n != 10'h3ff) done_n <= done_n + 10'h001;
  end

  // Width of the last low pulse on the reset pin
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      low_n <= 10'h000;
      last_low <= 10'h000;
    end else if (!creset_n) begin
      if (low_n != 10'h3ff) low_n <= low_n + 10'h001;
    end else begin
      if (low_n != 10'h000) last_low <= low_n;
      low_n <= 10'h000;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) tck_n <= 4'h0;
    else if (tck) tck_n <= 4'h0;
    else if (tck_n != 4'hf) tck_n <= tck_n + 4'h1;
  end

  // --------------------------------------------------------------
  // Properties
  // --------------------------------------------------------------
  user_delay_a: assert property (
    $rose(user_mode) |-> done_n >= USER_MIN_CYC)
    else $error("user mode entered too early");
  user_done_a: assert property (
    user_mode |-> config_done_flag)
    else $error("user mode without done");
  restart_user_a: assert property (
    $rose(config_done_flag) |-> !user_mode)
    else $error("user mode already set at done");
  reset_width_a: assert property (
    $fell(config_done_flag) |-> last_low >= CRESET_MIN_CYC)
    else $error("restart after short reset pulse");
  clk_high_a: assert property (
    $rose(config_clock_o) |=> config_clock_o)
    else $error("config clock high too short");
  clk_low_a: assert property (
    $fell(config_clock_o) |=> !config_clock_o)
    else $error("config clock low too short");
  tdo_fall_a: assert property (
    $changed(tdo) |-> !tck && tck_n inside {[4'h1:4'h9]})
    else $error("tdo changed away from tck fall");
  bus_okay_a: assert property (
    hreadyout && !hresp)
    else $error("bus wait or error response");

  cover property ($rose(user_mode));
  cover property ($fell(config_done_flag));
  cover property ($changed(tdo));
endmodule // fcs_seq_props

bind fcs_sequencer fcs_seq_props u_props (.hclk, .hresetn, .hreadyout,
  .hresp, .creset_n, .config_clock_o, .config_done_flag, .user_mode,
  .tck, .tdo);

//--- testbench/fcs_host_model.sv
// Configuration host model: reset pulses and passive clock
`timescale 1ns/1ns
module fcs_host_model (
  input  wire logic       hclk,           // Clock
  input  wire logic       user_mode,      // Device user mode
  output logic            creset_n,       // Config reset
  output logic            config_clock_i, // Passive clock
  output logic      [7:0] config_data,    // Data pins
  output logic            sys_rst_n       // System reset
);
  import fcs_pkg::*;

  initial begin
    creset_n = 1'h1;
    config_clock_i = 1'h0;
    config_data = 8'h00;
  end

  // Interface held in reset until user mode
  assign sys_rst_n = user_mode;

  // Data pins never hold a stale value
  always @(posedge hclk) config_data <= config_data + 8'h01;

  task pulse(input int n);
    creset_n <= 1'h0;
    repeat (n) @(posedge hclk);
    creset_n <= 1'h1;
  endtask

  task tick;
    config_clock_i <= 1'h1;
    repeat (3) @(posedge hclk);
    config_clock_i <= 1'h0;
    repeat (3) @(posedge hclk);
  endtask

  // Early tick must be ignored by the device
  task feed(input int n);
    tick();
    repeat (DATA_DELAY_CYC + 8) @(posedge hclk);
    repeat (n) tick();
  endtask
endmodule // fcs_host_model

//--- testbench/testbench.sv
// Testbench of the configuration sequencer
`timescale 1ns/1ns
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin n_fail++; \
  $display("BAD t=%0t got %h exp %h", $time, a, e); end end
module testbench;
  import fcs_pkg::*;
  localparam int LEN = 8;
  localparam logic [31:0] SMASK = 32'h1f << ST_BY_EIGHT_BIT;
  localparam logic [31:0] SUP = (32'h1 << ST_DONE_BIT) |
                                (32'h1 << ST_USER_BIT);
  logic        hclk = 1'h0, hresetn = 1'h0, hsel = 1'h0, hwrite = 1'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic        hready, hreadyout, hresp, creset_n, config_clock_i;
  logic        config_clock_o, config_clock_oe, config_done_flag;
  logic        user_mode, tdo, sys_rst_n, run_tck = 1'h0;
  logic [7:0]  config_data;
  logic        tck = 1'h0, tdi = 1'h0, tap_update_ir = 1'h0;
  logic        tap_capture_dr = 1'h0, enter_user_cmd = 1'h0;
  logic        prev_o = 1'h0, prev_tdo = 1'h0;
  int n_fail = 0, compares = 0, cyc = 0, rises = 0, per = 0, last = 0;
  int tdo_bad = 0, td, tu, r0, t0;

  assign hready = hreadyout;
  fcs_sequencer uut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .creset_n,
    .config_clock_i, .config_clock_o, .config_clock_oe, .config_data,
    .config_done_flag, .user_mode, .tck, .tdi, .tdo, .tap_update_ir,
    .tap_capture_dr, .enter_user_cmd);
  fcs_host_model host (.hclk, .user_mode, .creset_n, .config_clock_i,
    .config_data, .sys_rst_n);

  always #25 hclk = ~hclk;

  // --------------------------------------------------------------
  // Monitors
  // --------------------------------------------------------------
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    prev_o <= config_clock_o;
    prev_tdo <= tdo;
    if (config_clock_o && !prev_o) begin
      rises <= rises + 1;
      per <= cyc - last;
      last <= cyc;
    end
    if (tck && tdo !== prev_tdo) tdo_bad <= tdo_bad + 1;
  end

  always begin
    repeat (10) @(posedge hclk);
    if (run_tck) tck <= ~tck;
    if (run_tck && tck) tdi <= ~tdi;
  end

  // --------------------------------------------------------------
  // Tasks
  // --------------------------------------------------------------
  task summarize;
    if (n_fail == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task bus(input logic w, input logic [7:0] a, input logic [31:0] d,
           output logic [31:0] r);
    int n;
    n = 0;
    hsel <= 1'h1;
    haddr <= {24'h000000, a};
    hwrite <= w;
    htrans <= 2'h2;
    do begin @(posedge hclk); n++; end while (hready !== 1'h1 && n < 50);
    htrans <= 2'h0;
    hwdata <= d;
    do begin @(posedge hclk); n++; end while (hready !== 1'h1 && n < 99);
    r = hrdata;
    if (n >= 99) begin n_fail++; summarize(); end
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'h1, a, d, r);
  endtask

  task rc(input logic [7:0] a, input logic [31:0] e,
          input logic [31:0] m = 32'hffff_ffff);
    logic [31:0] r;
    bus(1'h0, a, 32'h0, r);
    `CHK(r & m, e)
  endtask

  task wait_hi(input logic u, output int t);
    int n;
    n = 0;
    while (((u ? user_mode : config_done_flag) !== 1'h1) && n < 4000) begin
      @(posedge hclk);
      n++;
    end
    if (n >= 4000) begin n_fail++; summarize(); end
    t = cyc;
  endtask

  task run(input logic [31:0] ctrl);
    wr(CTRL_OFS, ctrl);
    host.pulse(CRESET_MIN_CYC);
    repeat (8) @(posedge hclk);
    if (ctrl[3]) begin
      host.feed(LEN - 1);
      rc(COUNT_OFS, LEN - 1);
      host.tick();
    end
    wait_hi(1'h0, td);
    r0 = rises;
    if (!ctrl[4]) wait_hi(1'h1, tu);
  endtask

  // --------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------
  initial begin
    repeat (12) @(posedge hclk);
    hresetn <= 1'h1;
    @(posedge hclk);
    rc(CTRL_OFS, {26'h0, CTRL_RESET});
    rc(LENGTH_OFS, LENGTH_RESET);
    wr(8'h10, 32'hffff_ffff);
    rc(8'h10, 32'h0);
    `CHK(config_done_flag, 1'h0)
    wr(LENGTH_OFS, LEN);
    run(32'h0);
    `CHK(per, 4)
    `CHK(config_clock_oe, 1'h1)
    rc(COUNT_OFS, LEN);
    `CHK(tu - td >= USER_MIN_CYC, 1'h1)
    host.pulse(CRESET_MIN_CYC - 1);
    repeat (40) @(posedge hclk);
    `CHK({config_done_flag, user_mode}, 2'h3)
    run(32'h4);
    `CHK(per, 8)
    rc(STATUS_OFS, SUP | (32'h1 << ST_BY_EIGHT_BIT), SMASK);
    run(32'h25);
    `CHK(per, 4)
    rc(STATUS_OFS, SUP, SMASK);
    `CHK(rises - r0, CHAIN_BITS >> 1)
    for (int w = 0; w < 4; w++) begin
      run(32'h8 | w);
      rc(COUNT_OFS, LEN);
      `CHK(config_clock_oe, 1'h0)
    end
    run(32'h18);
    enter_user_cmd <= 1'h1;
    @(posedge hclk);
    enter_user_cmd <= 1'h0;
    repeat (300) @(posedge hclk);
    `CHK(user_mode, 1'h0)
    enter_user_cmd <= 1'h1;
    tap_update_ir <= 1'h1;
    t0 = cyc;
    @(posedge hclk);
    enter_user_cmd <= 1'h0;
    tap_update_ir <= 1'h0;
    wait_hi(1'h1, tu);
    `CHK(tu - t0 >= USER_MIN_CYC, 1'h1)
    tap_capture_dr <= 1'h1;
    @(posedge hclk);
    tap_capture_dr <= 1'h0;
    run_tck <= 1'h1;
    repeat (300) @(posedge hclk);
    run_tck <= 1'h0;
    `CHK(tdo_bad, 0)
    summarize();
  end
endmodule // testbench
